//--- tcio_params.svh
`ifndef TCIO_PARAMS_SVH
`define TCIO_PARAMS_SVH

// register byte offsets
`define TCIO_OFS_IOCTL_HIGH 8'h00
`define TCIO_OFS_IOCTL_LOW 8'h04
`define TCIO_OFS_GR_B 8'h08
`define TCIO_OFS_GR_D 8'h0C
`define TCIO_OFS_MODE 8'h10
`define TCIO_OFS_CH4_PRESCALE 8'h14
`define TCIO_OFS_STATUS 8'h18

// field positions
`define TCIO_IOCTL_MSB 7
`define TCIO_IOCTL_LSB 4
`define TCIO_MODE_BUFFER_BIT 0
`define TCIO_PRESCALE_MSB 2
`define TCIO_ST_MATCH_B 0
`define TCIO_ST_MATCH_D 1
`define TCIO_ST_CAPT_B 2
`define TCIO_ST_CAPT_D 3
`define TCIO_ST_PIN_LEVEL 8
`define TCIO_ST_PIN_IN 10

// reset values
`define TCIO_RST_IOCTL 4'h0
`define TCIO_RST_GR 16'hFFFF
`define TCIO_RST_BUFFER 1'b0
`define TCIO_RST_PRESCALE 3'h0

// prescale code for the undivided peripheral clock
`define TCIO_PRESCALE_UNDIV 3'h0

`endif

//--- tcio_pkg.sv
package tcio_pkg;

  typedef enum logic [2:0] {
    TCIO_OC_OFF,
    TCIO_OC_LOW,
    TCIO_OC_HIGH,
    TCIO_OC_TOGGLE,
    TCIO_IC_RISE,
    TCIO_IC_FALL,
    TCIO_IC_BOTH,
    TCIO_IC_CH4
  } tcio_mode_t;

  function automatic tcio_mode_t tcio_decode(input logic [3:0] f);
    tcio_mode_t m;
    m = TCIO_OC_OFF;
    if (!f[3]) begin
      case (f[1:0])
        2'h1: m = TCIO_OC_LOW;
        2'h2: m = TCIO_OC_HIGH;
        2'h3: m = TCIO_OC_TOGGLE;
        default: m = TCIO_OC_OFF;
      endcase
    end else if (f[2]) begin
      m = TCIO_IC_CH4;
    end else if (f[1]) begin
      m = TCIO_IC_BOTH;
    end else if (f[0]) begin
      m = TCIO_IC_FALL;
    end else begin
      m = TCIO_IC_RISE;
    end
    return m;
  endfunction : tcio_decode

endpackage : tcio_pkg

//--- tcio_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tcio_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin side
  input wire logic pin_in,
  // filtered level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1;
  logic s2;
  logic s3;
  logic agree;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the second and third stages agree
  assign agree = (s2 == s3);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      if (agree) begin
        level <= s3;
      end
      rise <= agree && s3 && !level;
      fall <= agree && !s3 && level;
    end
  end

endmodule : tcio_pin_sync

`default_nettype wire

//--- tcio_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcio_params.svh"

// Overview of operation
// [RQ1] output mode x0x01: pin driven low at each compare match, bit 6 sets start level
// [RQ2] output mode x0x10: pin driven high at each compare match, bit 6 sets start level
// [RQ3] output mode x0x11: pin toggles at each compare match, bit 6 sets start level
// [RQ4] code 1000: capture counter into general register on pin rising edge
// [RQ5] code 1001: capture counter into general register on pin falling edge
// [RQ6] code 101x: capture counter on both pin edges
// [RQ7] code 11xx: capture on each channel 4 count up or count down
// [RQ8] channel 4 on undivided clock: channel 4 triggered capture never happens
// [RQ9] register D in buffer mode: no capture and no compare for it
// [RQ10] codes 0000 and 0100: pin output off, compare still runs
// [RQ11] fields B and D decoded independently, each owns its register and pin
module tcio_top
  import tcio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // timer counters, same clock
  input wire logic [15:0] ch3_counter,
  input wire logic ch4_count_up,
  input wire logic ch4_count_down,
  // channel pin b
  input wire logic ch3_pin_b_in,
  output logic ch3_pin_b_out,
  output logic ch3_pin_b_oe,
  // channel pin d
  input wire logic ch3_pin_d_in,
  output logic ch3_pin_d_out,
  output logic ch3_pin_d_oe
);

  // index 0 serves register B, index 1 register D
  localparam int NCH = 2;

  logic [3:0] ioctl [NCH];
  logic [3:0] ioctl_prev [NCH];
  logic [15:0] gr [NCH];
  logic regd_buffer_mode;
  logic [2:0] ch4_prescale_sel;
  logic [1:0] st_match;
  logic [1:0] st_capt;
  logic [1:0] pin_level;
  logic [1:0] pin_oe;
  logic [1:0] eq_prev;

  logic [1:0] in_level;
  logic [1:0] in_rise;
  logic [1:0] in_fall;

  tcio_mode_t mode [NCH];
  logic [1:0] active;
  logic [1:0] is_output;
  logic [1:0] match;
  logic [1:0] capture;
  logic ch4_trig;

  logic req;
  logic req_ok;
  logic hit;
  logic wr;
  logic [31:0] rd_data;

  // pin inputs from outside the clock domain
  tcio_pin_sync u_sync_b (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(ch3_pin_b_in),
    .level(in_level[0]),
    .rise(in_rise[0]),
    .fall(in_fall[0])
  );

  tcio_pin_sync u_sync_d (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(ch3_pin_d_in),
    .level(in_level[1]),
    .rise(in_rise[1]),
    .fall(in_fall[1])
  );

  // channel 4 trigger only counts when channel 4 runs on a divided clock
  assign ch4_trig = (ch4_count_up || ch4_count_down)
                    && (ch4_prescale_sel != `TCIO_PRESCALE_UNDIV); // [RQ7] [RQ8]

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      mode[i] = tcio_decode(ioctl[i]); // [RQ11]
      is_output[i] = !ioctl[i][3];
    end
  end

  // register D loses both functions while it serves as a buffer
  assign active[0] = 1'b1;
  assign active[1] = !regd_buffer_mode; // [RQ9]

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match[i] = active[i] && is_output[i]
                 && (ch3_counter == gr[i]) && !eq_prev[i];
      case (mode[i])
        TCIO_IC_RISE: capture[i] = in_rise[i]; // [RQ4]
        TCIO_IC_FALL: capture[i] = in_fall[i]; // [RQ5]
        TCIO_IC_BOTH: capture[i] = in_rise[i] || in_fall[i]; // [RQ6]
        TCIO_IC_CH4: capture[i] = ch4_trig; // [RQ7]
        default: capture[i] = 1'b0;
      endcase
      capture[i] = capture[i] && active[i]; // [RQ9]
    end
  end

  // compare match is taken on the cycle the counter first equals the register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eq_prev <= 2'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        eq_prev[i] <= (ch3_counter == gr[i]);
      end
    end
  end

  // ---- wishbone slave ----
  assign req = wb_cyc_i && wb_stb_i;
  assign hit = (wb_adr_i == `TCIO_OFS_IOCTL_HIGH) || (wb_adr_i == `TCIO_OFS_IOCTL_LOW)
               || (wb_adr_i == `TCIO_OFS_GR_B) || (wb_adr_i == `TCIO_OFS_GR_D)
               || (wb_adr_i == `TCIO_OFS_MODE) || (wb_adr_i == `TCIO_OFS_CH4_PRESCALE)
               || (wb_adr_i == `TCIO_OFS_STATUS);
  assign req_ok = req && !wb_ack_o && !wb_err_o;
  // writes land on the edge where the master sees ack
  assign wr = req && wb_we_i && wb_ack_o;

  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `TCIO_OFS_IOCTL_HIGH: rd_data[`TCIO_IOCTL_MSB:`TCIO_IOCTL_LSB] = ioctl[0];
      `TCIO_OFS_IOCTL_LOW: rd_data[`TCIO_IOCTL_MSB:`TCIO_IOCTL_LSB] = ioctl[1];
      `TCIO_OFS_GR_B: rd_data[15:0] = gr[0];
      `TCIO_OFS_GR_D: rd_data[15:0] = gr[1];
      `TCIO_OFS_MODE: rd_data[`TCIO_MODE_BUFFER_BIT] = regd_buffer_mode;
      `TCIO_OFS_CH4_PRESCALE: rd_data[`TCIO_PRESCALE_MSB:0] = ch4_prescale_sel;
      `TCIO_OFS_STATUS: begin
        rd_data[`TCIO_ST_MATCH_B] = st_match[0];
        rd_data[`TCIO_ST_MATCH_D] = st_match[1];
        rd_data[`TCIO_ST_CAPT_B] = st_capt[0];
        rd_data[`TCIO_ST_CAPT_D] = st_capt[1];
        rd_data[`TCIO_ST_PIN_LEVEL+1:`TCIO_ST_PIN_LEVEL] = pin_level;
        rd_data[`TCIO_ST_PIN_IN+1:`TCIO_ST_PIN_IN] = in_level;
      end
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req_ok && hit;
      wb_err_o <= req_ok && !hit;
      if (req_ok) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // ---- control registers ----
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioctl[0] <= `TCIO_RST_IOCTL;
      ioctl[1] <= `TCIO_RST_IOCTL;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == `TCIO_OFS_IOCTL_HIGH) begin
        ioctl[0] <= wb_dat_i[`TCIO_IOCTL_MSB:`TCIO_IOCTL_LSB];
      end
      if (wb_adr_i == `TCIO_OFS_IOCTL_LOW) begin
        ioctl[1] <= wb_dat_i[`TCIO_IOCTL_MSB:`TCIO_IOCTL_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regd_buffer_mode <= `TCIO_RST_BUFFER;
      ch4_prescale_sel <= `TCIO_RST_PRESCALE;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == `TCIO_OFS_MODE) begin
        regd_buffer_mode <= wb_dat_i[`TCIO_MODE_BUFFER_BIT];
      end
      if (wb_adr_i == `TCIO_OFS_CH4_PRESCALE) begin
        ch4_prescale_sel <= wb_dat_i[`TCIO_PRESCALE_MSB:0];
      end
    end
  end

  // general registers: a capture wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gr[0] <= `TCIO_RST_GR;
      gr[1] <= `TCIO_RST_GR;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (capture[i]) begin
          gr[i] <= ch3_counter; // [RQ4] [RQ5] [RQ6] [RQ7]
        end else if (wr && (wb_adr_i == (i == 0 ? `TCIO_OFS_GR_B : `TCIO_OFS_GR_D))) begin
          if (wb_sel_i[0]) begin
            gr[i][7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            gr[i][15:8] <= wb_dat_i[15:8];
          end
        end
      end
    end
  end

  // sticky status: a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_match <= 2'h0;
      st_capt <= 2'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (match[i]) begin
          st_match[i] <= 1'b1;
        end else if (wr && wb_sel_i[0] && (wb_adr_i == `TCIO_OFS_STATUS)
                     && wb_dat_i[`TCIO_ST_MATCH_B + i]) begin
          st_match[i] <= 1'b0;
        end
        if (capture[i]) begin
          st_capt[i] <= 1'b1;
        end else if (wr && wb_sel_i[0] && (wb_adr_i == `TCIO_OFS_STATUS)
                     && wb_dat_i[`TCIO_ST_CAPT_B + i]) begin
          st_capt[i] <= 1'b0;
        end
      end
    end
  end

  // ---- pin output ----
  // a newly written output code loads the start level from bit 6
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioctl_prev[0] <= `TCIO_RST_IOCTL;
      ioctl_prev[1] <= `TCIO_RST_IOCTL;
      pin_level <= 2'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ioctl_prev[i] <= ioctl[i];
        if (ioctl[i] != ioctl_prev[i]) begin
          pin_level[i] <= ioctl[i][2]; // [RQ1] [RQ2] [RQ3]
        end else if (match[i]) begin
          case (mode[i])
            TCIO_OC_LOW: pin_level[i] <= 1'b0; // [RQ1]
            TCIO_OC_HIGH: pin_level[i] <= 1'b1; // [RQ2]
            TCIO_OC_TOGGLE: pin_level[i] <= !pin_level[i]; // [RQ3]
            default: pin_level[i] <= pin_level[i];
          endcase
        end
      end
    end
  end

  // output driven only in an active output mode other than off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe <= 2'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pin_oe[i] <= active[i] && is_output[i] && (mode[i] != TCIO_OC_OFF); // [RQ10] [RQ9]
      end
    end
  end

  // pin ports are copies of flip-flops so each output stays registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ch3_pin_b_out <= 1'b0;
      ch3_pin_b_oe <= 1'b0;
      ch3_pin_d_out <= 1'b0;
      ch3_pin_d_oe <= 1'b0;
    end else begin
      ch3_pin_b_out <= pin_level[0]; // [RQ11]
      ch3_pin_b_oe <= pin_oe[0];
      ch3_pin_d_out <= pin_level[1]; // [RQ11]
      ch3_pin_d_oe <= pin_oe[1];
    end
  end

endmodule : tcio_top

`default_nettype wire

//--- tcio_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcio_pin_model (
  // design side
  input wire logic pin_out,
  input wire logic pin_oe,
  // far device
  input wire logic ext_level,
  output logic pin_in
);
  // the design's drive wins; released, the outside device sets the line
  assign pin_in = pin_oe ? pin_out : ext_level;
endmodule : tcio_pin_model
`default_nettype wire

//--- tcio_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tcio_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // counter and pins
  input wire logic [15:0] ch3_counter,
  input wire logic ch3_pin_b_out,
  input wire logic ch3_pin_b_oe,
  input wire logic ch3_pin_d_out,
  input wire logic ch3_pin_d_oe
);
  logic [3:0] fb;
  logic [3:0] fd;
  logic [15:0] grb;
  logic bufd;
  logic [1:0] settle;
  logic wr;
  assign wr = wb_ack_o && wb_we_i;
  // control mirror; settle hides the two-edge lag after any write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb <= 4'h0;
      fd <= 4'h0;
      grb <= 16'hFFFF;
      bufd <= 1'b0;
      settle <= 2'h0;
    end else begin
      settle <= wr ? 2'h0 : settle + {1'b0, settle != 2'h3};
      if (wr && wb_adr_i == 8'h00) fb <= wb_dat_i[7:4];
      if (wr && wb_adr_i == 8'h04) fd <= wb_dat_i[7:4];
      if (wr && wb_adr_i == 8'h08) grb <= wb_dat_i[15:0];
      if (wr && wb_adr_i == 8'h10) bufd <= wb_dat_i[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_single_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o) else $error("request not answered once");
  chk_oe_b_mode: assert property (settle == 2'h3 |->
    ch3_pin_b_oe == (!fb[3] && fb[1:0] != 2'h0)) else $error("pin b enable wrong");
  chk_oe_d_mode: assert property (settle == 2'h3 && !bufd |->
    ch3_pin_d_oe == (!fd[3] && fd[1:0] != 2'h0)) else $error("pin d enable wrong");
  chk_low_only_b: assert property (settle == 2'h3 && fb[3:2] != 2'h2 && fb[1:0] == 2'h1
    && !fb[3] |-> !$rose(ch3_pin_b_out)) else $error("pin b rose in low mode");
  chk_high_only_d: assert property (settle == 2'h3 && !bufd && !fd[3] && fd[1:0] == 2'h2
    |-> !$fell(ch3_pin_d_out)) else $error("pin d fell in high mode");
  chk_toggle_b: assert property (settle == 2'h3 && !fb[3] && fb[1:0] == 2'h3
    && ch3_counter == grb && $past(ch3_counter) != grb
    |-> ##3 ch3_pin_b_out != $past(ch3_pin_b_out, 3)) else $error("pin b no toggle");
  chk_capture_quiet: assert property (settle == 2'h3 && fb[3]
    |-> $stable(ch3_pin_b_out)) else $error("pin b moved in capture mode");
  chk_buffer_quiet: assert property (settle == 2'h3 && bufd
    |-> $stable(ch3_pin_d_out)) else $error("pin d moved in buffer mode");
endmodule : tcio_checker
bind tcio_top tcio_checker tcio_checker_i (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .ch3_counter, .ch3_pin_b_out,
  .ch3_pin_b_oe, .ch3_pin_d_out, .ch3_pin_d_oe);
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack, err, e;
  logic [31:0] q;
  logic [15:0] cnt = 16'h0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic ext_b = 1'b0;
  logic ext_d = 1'b0;
  logic pb_in, pb_out, pb_oe, pd_in, pd_out, pd_oe;
  int err_total = 0;
  int checks = 0;
  always #10 clk = ~clk;
  tcio_top tcio_top_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .ch3_counter(cnt), .ch4_count_up(up),
    .ch4_count_down(dn), .ch3_pin_b_in(pb_in), .ch3_pin_b_out(pb_out),
    .ch3_pin_b_oe(pb_oe), .ch3_pin_d_in(pd_in), .ch3_pin_d_out(pd_out), .ch3_pin_d_oe(pd_oe));
  tcio_pin_model tcio_pin_model_i (.pin_out(pb_out), .pin_oe(pb_oe), .ext_level(ext_b),
    .pin_in(pb_in));
  tcio_pin_model tcio_pin_model_d_i (.pin_out(pd_out), .pin_oe(pd_oe), .ext_level(ext_d),
    .pin_in(pd_in));
  task automatic results();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (!(ack | err));
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : bus
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    int k, v, g, p;
    v = $urandom(32'hEF35008D);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    `CHK({pb_oe, pd_oe}, 2'b00)
    bus(1'b0, 8'h1C, 32'h0);
    `CHK(e, 1'b1)
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        k = $urandom_range(16'hFFF0, 16'h0010);
        bus(1'b1, 8'(8 + 4 * ch), 32'(k));
        bus(1'b1, 8'(4 * ch), 32'(c << 4));
        repeat (6) @(posedge clk);
        p = (c >> 2) & 1;
        `CHK(ch ? pd_oe : pb_oe, 1'(c % 4 != 0))
        `CHK(ch ? pb_oe : pd_oe, 1'(ch))
        if (c % 4 != 0) `CHK(ch ? pd_out : pb_out, 1'(p))
        // with the pin off, a compare match must still raise its sticky flag
        if (c == 0) begin
          bus(1'b0, 8'h18, 32'h0);
          `CHK(q[ch], 1'b0)
        end
        cnt <= 16'(k - 1);
        @(posedge clk);
        cnt <= 16'(k);
        repeat (6) @(posedge clk);
        p = (c % 4 == 1) ? 0 : (c % 4 == 2) ? 1 : (c % 4 == 3) ? !p : p;
        if (c % 4 != 0) `CHK(ch ? pd_out : pb_out, 1'(p))
        if (c == 0) begin
          bus(1'b0, 8'h18, 32'h0);
          `CHK(q[ch], 1'b1)
        end
      end
    end
    // rise then fall on the pin, or a count up then down on channel 4
    bus(1'b1, 8'h14, 32'h1);
    for (int c = 8; c < 13; c++) begin
      bus(1'b1, 8'h00, 32'(c << 4));
      repeat (6) @(posedge clk);
      bus(1'b1, 8'h08, 32'h0);
      g = 0;
      for (int s = 0; s < 2; s++) begin
        v = $urandom_range(16'hFFFF, 16'h0001);
        cnt <= 16'(v);
        up <= (c == 12) && !s;
        dn <= (c == 12) && s;
        if (c != 12) ext_b <= !s;
        @(posedge clk);
        up <= 1'b0;
        dn <= 1'b0;
        repeat (8) @(posedge clk);
        if (c > 9 || (c == 8 && s == 0) || (c == 9 && s == 1)) g = v;
        bus(1'b0, 8'h08, 32'h0);
        `CHK(q[15:0], 16'(g))
      end
    end
    bus(1'b1, 8'h14, 32'h0);
    cnt <= 16'h1234;
    up <= 1'b1;
    @(posedge clk);
    up <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK(q[15:0], 16'(g))
    bus(1'b1, 8'h04, 32'h80);
    repeat (6) @(posedge clk);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    ext_d <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    `CHK(q[15:0], 16'h0000)
    // a toggle code on the buffered register must not compare either
    bus(1'b1, 8'h04, 32'h30);
    bus(1'b1, 8'h18, 32'h2);
    cnt <= 16'h0001;
    @(posedge clk);
    cnt <= 16'h0000;
    repeat (6) @(posedge clk);
    bus(1'b0, 8'h18, 32'h0);
    `CHK(q[1], 1'b0)
    `CHK(pd_out, 1'b0)
    results();
  end
endmodule : tb_top
`default_nettype wire
